// File: spic_ctrl_irq.sv
// control, baud, interrupt enable and interrupt flag registers of the spi block
// assumes a shift engine beside it; all its inputs are synchronous to clock
`default_nettype none

// Function
// - hardware drives select during master transfers
// - select falling edge raises wake request
// - idle preload moves written word to shifter
// - char size: 0 eight bits, 1 nine
// - eight-bit baud register, reset zero
// - enable-clear: ones clear, reads show enables
// - enable-set: ones set, reads show enables
// - both enable registers share one set
// - error flag set on overflow, write-one clears
// - slave select falling sets select-low flag
// - rx complete while unread data, read clears
// - address delivered as first received word
// - master: shifted out, nothing waiting, sets txc
// - slave: select rising sets txc, match gated
// - tx empty flag while transmit buffer empty
// - control settings act directly, unsynchronised
// - overflow status set, cleared, overrunning word reads zero
// - data read gives rx, write loads tx
module spic_ctrl_irq
	import spic_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	input  wire logic [DATA_W-1:0] reg_wdata,
	output var  logic [DATA_W-1:0] reg_rdata,
	input  wire logic              master_mode,
	input  wire logic              rx_enable,
	input  wire logic              addr_match_enable,
	input  wire logic              rx_valid,
	input  wire logic              addr_match,
	input  wire logic [CHAR_W-1:0] rx_data,
	input  wire logic              rx_overflow,
	input  wire logic              tx_taken,
	input  wire logic              shift_done,
	input  wire logic              xfer_active,
	input  wire logic              select_pin,
	output var  logic              hw_select_enable,
	output var  logic              select_low_detect_enable,
	output var  logic              slave_preload_enable,
	output var  logic [2:0]        char_size,
	output var  logic [7:0]        baud_divider,
	output var  logic [CHAR_W-1:0] tx_word,
	output var  logic              tx_word_valid,
	output var  logic              preload_strobe,
	output var  logic              select_out_b,
	output var  logic              wake_req,
	output var  logic              irq
);

	spic_state_t r_reg;
	spic_state_t r_next;

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	logic [7:0] flag_view;
	logic       wr_data;
	logic       rd_data;
	logic       ss_fall;
	logic       ss_rise;
	logic       ovf_event;
	logic       rx_load;

	always_comb
	begin
		r_next    = r_reg;
		wr_data   = reg_wr && hit(reg_addr, OFF_DATA);
		rd_data   = reg_rd && hit(reg_addr, OFF_DATA);
		ss_fall   = r_reg.ss_prev && !select_pin;
		ss_rise   = !r_reg.ss_prev && select_pin;
		rx_load   = rx_valid || addr_match;
		ovf_event = rx_overflow || (rx_load && r_reg.rx_full && !rd_data);

		r_next.ss_prev = select_pin;
		r_next.preload = 1'b0;
		r_next.wake    = 1'b0;

		// settings written here feed the engine with no synchroniser stage
		if (reg_wr && hit(reg_addr, OFF_CONTROL_SECOND))
		begin
			r_next.ctrl.hw_select_enable         = reg_wdata[POS_HW_SELECT_ENABLE];
			r_next.ctrl.select_low_detect_enable = reg_wdata[POS_SELECT_LOW_DETECT];
			r_next.ctrl.slave_preload_enable     = reg_wdata[POS_SLAVE_PRELOAD];
			// reserved codes are stored as written; the engine treats them as eight bits
			r_next.ctrl.char_size = reg_wdata[POS_CHAR_SIZE +: 3];
		end
		else if (reg_wr && hit(reg_addr, OFF_BAUD_DIVIDER))
		begin
			r_next.baud = reg_wdata[7:0];
		end
		else if (reg_wr && hit(reg_addr, OFF_IRQ_ENABLE_CLEAR))
		begin
			r_next.inten = r_reg.inten & ~(reg_wdata[7:0] & IRQ_IMPL_MASK);
		end
		else if (reg_wr && hit(reg_addr, OFF_IRQ_ENABLE_SET))
		begin
			r_next.inten = r_reg.inten | (reg_wdata[7:0] & IRQ_IMPL_MASK);
		end

		// write-one clears first, hardware sets afterwards so a same-cycle set wins
		if (reg_wr && hit(reg_addr, OFF_IRQ_FLAG_STATUS))
		begin
			if (reg_wdata[POS_ERROR_FLAG])
				r_next.flags.error_flag = 1'b0;
			if (reg_wdata[POS_SELECT_LOW])
				r_next.flags.select_low_flag = 1'b0;
			if (reg_wdata[POS_TX_COMPLETE])
				r_next.flags.tx_complete_flag = 1'b0;
		end
		if (reg_wr && hit(reg_addr, OFF_STATUS) && reg_wdata[POS_OVERFLOW])
			r_next.flags.overflow_flag = 1'b0;

		// receive side
		if (rd_data)
			r_next.rx_full = 1'b0;
		if (rx_load)
		begin
			r_next.rx_full = 1'b1;
			r_next.rx_buf  = ovf_event ? '0 : rx_data;
		end
		if (ovf_event)
		begin
			r_next.flags.overflow_flag = 1'b1;
			r_next.flags.error_flag    = 1'b1;
		end
		if (!rx_enable)
		begin
			r_next.rx_full             = 1'b0;
			r_next.flags.overflow_flag = 1'b0;
		end

		// transmit side
		if (tx_taken)
			r_next.tx_full = 1'b0;
		if (wr_data)
		begin
			r_next.tx_buf                 = reg_wdata[CHAR_W-1:0];
			r_next.flags.tx_complete_flag = 1'b0;
			if (!master_mode && r_reg.ctrl.slave_preload_enable && !xfer_active && select_pin)
				r_next.preload = 1'b1;
			else
				r_next.tx_full = 1'b1;
		end
		if (master_mode && shift_done && !r_next.tx_full)
			r_next.flags.tx_complete_flag = 1'b1;

		// slave select edges
		if (!master_mode && ss_fall)
		begin
			r_next.txn_open    = 1'b1;
			r_next.txn_matched = 1'b0;
			if (r_reg.ctrl.select_low_detect_enable)
			begin
				r_next.flags.select_low_flag = 1'b1;
				r_next.wake                  = 1'b1;
			end
		end
		if (addr_match && r_reg.txn_open)
			r_next.txn_matched = 1'b1;
		if (!master_mode && ss_rise && r_reg.txn_open)
		begin
			r_next.txn_open = 1'b0;
			if (!addr_match_enable || r_reg.txn_matched || addr_match)
				r_next.flags.tx_complete_flag = 1'b1;
		end

		// select is only driven low while a master transfer runs
		r_next.select_out_b = !(r_reg.ctrl.hw_select_enable && master_mode && xfer_active);

		flag_view = '0;
		flag_view[POS_ERROR_FLAG]  = r_next.flags.error_flag;
		flag_view[POS_SELECT_LOW]  = r_next.flags.select_low_flag;
		flag_view[POS_RX_COMPLETE] = r_next.rx_full;
		flag_view[POS_TX_COMPLETE] = r_next.flags.tx_complete_flag;
		flag_view[POS_TX_EMPTY]    = !r_next.tx_full;
		r_next.irq = |(flag_view & r_next.inten);

		// read data is taken in the cycle of the strobe and shows one edge later
		if (reg_rd)
		begin
			r_next.rdata = '0;
			if (hit(reg_addr, OFF_CONTROL_SECOND))
			begin
				r_next.rdata[POS_HW_SELECT_ENABLE]  = r_reg.ctrl.hw_select_enable;
				r_next.rdata[POS_SELECT_LOW_DETECT] = r_reg.ctrl.select_low_detect_enable;
				r_next.rdata[POS_SLAVE_PRELOAD]     = r_reg.ctrl.slave_preload_enable;
				r_next.rdata[POS_CHAR_SIZE +: 3]    = r_reg.ctrl.char_size;
			end
			else if (hit(reg_addr, OFF_BAUD_DIVIDER))
				r_next.rdata[7:0] = r_reg.baud;
			else if (hit(reg_addr, OFF_IRQ_ENABLE_CLEAR) || hit(reg_addr, OFF_IRQ_ENABLE_SET))
				r_next.rdata[7:0] = r_reg.inten;
			else if (hit(reg_addr, OFF_IRQ_FLAG_STATUS))
			begin
				r_next.rdata[POS_ERROR_FLAG]  = r_reg.flags.error_flag;
				r_next.rdata[POS_SELECT_LOW]  = r_reg.flags.select_low_flag;
				r_next.rdata[POS_RX_COMPLETE] = r_reg.rx_full;
				r_next.rdata[POS_TX_COMPLETE] = r_reg.flags.tx_complete_flag;
				r_next.rdata[POS_TX_EMPTY]    = !r_reg.tx_full;
			end
			else if (hit(reg_addr, OFF_STATUS))
				r_next.rdata[POS_OVERFLOW] = r_reg.flags.overflow_flag;
			else if (hit(reg_addr, OFF_DATA))
				r_next.rdata[CHAR_W-1:0] = r_reg.rx_buf;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_b)
			r_reg <= STATE_RESET;
		else
			r_reg <= r_next;
	end

	assign reg_rdata                = r_reg.rdata;
	assign hw_select_enable         = r_reg.ctrl.hw_select_enable;
	assign select_low_detect_enable = r_reg.ctrl.select_low_detect_enable;
	assign slave_preload_enable     = r_reg.ctrl.slave_preload_enable;
	assign char_size                = r_reg.ctrl.char_size;
	assign baud_divider             = r_reg.baud;
	assign tx_word                  = r_reg.tx_buf;
	assign tx_word_valid            = r_reg.tx_full;
	assign preload_strobe           = r_reg.preload;
	assign select_out_b             = r_reg.select_out_b;
	assign wake_req                 = r_reg.wake;
	assign irq                      = r_reg.irq;

endmodule : spic_ctrl_irq

`default_nettype wire

// File: spic_pkg.sv
// constants, field layouts and state record for the spi control and interrupt block
// assumes a single 100 MHz clock and a simple byte-addressed register port
`default_nettype none

package spic_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CHAR_W = 9;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CONTROL_SECOND   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_BAUD_DIVIDER     = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_CLEAR = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE_SET   = 8'h16;
	localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG_STATUS  = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_STATUS           = 8'h1a;
	localparam logic [ADDR_W-1:0] OFF_DATA             = 8'h28;

	// control_second fields
	localparam int unsigned POS_HW_SELECT_ENABLE   = 13;
	localparam int unsigned POS_SELECT_LOW_DETECT  = 9;
	localparam int unsigned POS_SLAVE_PRELOAD      = 6;
	localparam int unsigned POS_CHAR_SIZE          = 0;

	// interrupt flag and enable bit positions
	localparam int unsigned POS_ERROR_FLAG   = 7;
	localparam int unsigned POS_SELECT_LOW   = 3;
	localparam int unsigned POS_RX_COMPLETE  = 2;
	localparam int unsigned POS_TX_COMPLETE  = 1;
	localparam int unsigned POS_TX_EMPTY     = 0;
	localparam logic [7:0]  IRQ_IMPL_MASK    = 8'h8f;

	// status fields
	localparam int unsigned POS_OVERFLOW = 2;

	// character size codes
	localparam logic [2:0] CHAR_SIZE_8 = 3'h0;
	localparam logic [2:0] CHAR_SIZE_9 = 3'h1;

	// reset values
	localparam logic [7:0] BAUD_RESET  = 8'h00;
	localparam logic [7:0] INTEN_RESET = 8'h00;

	typedef struct packed {
		logic             hw_select_enable;
		logic             select_low_detect_enable;
		logic             slave_preload_enable;
		logic [2:0]       char_size;
	} spic_ctrl_t;

	typedef struct packed {
		logic             error_flag;
		logic             select_low_flag;
		logic             tx_complete_flag;
		logic             overflow_flag;
	} spic_flags_t;

	typedef struct packed {
		spic_ctrl_t        ctrl;
		logic [7:0]        baud;
		logic [7:0]        inten;
		spic_flags_t       flags;
		logic              rx_full;
		logic [CHAR_W-1:0] rx_buf;
		logic              tx_full;
		logic [CHAR_W-1:0] tx_buf;
		logic              ss_prev;
		logic              txn_open;
		logic              txn_matched;
		logic [DATA_W-1:0] rdata;
		logic              irq;
		logic              wake;
		logic              select_out_b;
		logic              preload;
	} spic_state_t;

	localparam spic_state_t STATE_RESET = '{
		ctrl:         '{default: 1'b0},
		baud:         BAUD_RESET,
		inten:        INTEN_RESET,
		flags:        '{default: 1'b0},
		rx_full:      1'b0,
		rx_buf:       '0,
		tx_full:      1'b0,
		tx_buf:       '0,
		ss_prev:      1'b1,
		txn_open:     1'b0,
		txn_matched:  1'b0,
		rdata:        '0,
		irq:          1'b0,
		wake:         1'b0,
		select_out_b: 1'b1,
		preload:      1'b0
	};

endpackage : spic_pkg

`default_nettype wire

// File: spic_engine_model.sv
// behavioural shift engine with loopback, standing in for the far-side device
// assumes the control block beside it on the same clock
`default_nettype none

module spic_engine_model
	import spic_pkg::*;
#(
	parameter int DELAY = 3
)
(
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire logic              tx_word_valid,
	input  wire logic [CHAR_W-1:0] tx_word,
	output var  logic              tx_taken,
	output var  logic              shift_done,
	output var  logic              xfer_active,
	output var  logic              rx_valid,
	output var  logic [CHAR_W-1:0] rx_data
);
	int                cnt;
	logic [CHAR_W-1:0] sh;

	// rx_data shows the inverse outside a delivery so a stale word never matches
	always_ff @(posedge clock)
	begin
		tx_taken   <= 1'b0;
		shift_done <= 1'b0;
		rx_valid   <= 1'b0;
		rx_data    <= ~sh;
		if (!rst_b)
		begin
			xfer_active <= 1'b0;
			cnt         <= 0;
		end
		else if (!xfer_active && tx_word_valid && !tx_taken)
		begin
			tx_taken    <= 1'b1;
			sh          <= tx_word;
			xfer_active <= 1'b1;
			cnt         <= DELAY;
		end
		else if (xfer_active && cnt == 0)
		begin
			xfer_active <= 1'b0;
			shift_done  <= 1'b1;
			rx_valid    <= 1'b1;
			rx_data     <= sh;
		end
		else if (xfer_active)
			cnt <= cnt - 1;
	end
endmodule : spic_engine_model

`default_nettype wire

// File: spic_ctrl_irq_sva.sv
// port-level assertions for the spi control and interrupt block
// assumes the block's single clock and synchronous active-low reset
`default_nettype none

module spic_ctrl_irq_sva
	import spic_pkg::*;
(
	input wire logic              clock,
	input wire logic              rst_b,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic              master_mode,
	input wire logic              xfer_active,
	input wire logic              select_pin,
	input wire logic              hw_select_enable,
	input wire logic              select_low_detect_enable,
	input wire logic              slave_preload_enable,
	input wire logic [2:0]        char_size,
	input wire logic [7:0]        baud_divider,
	input wire logic [CHAR_W-1:0] tx_word,
	input wire logic              tx_word_valid,
	input wire logic              preload_strobe,
	input wire logic              select_out_b,
	input wire logic              wake_req
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_preload_wr;
		reg_wr && reg_addr == OFF_DATA && slave_preload_enable && !master_mode
			&& !xfer_active && select_pin;
	endsequence

	a_preload_pulse: assert property (s_preload_wr |=> preload_strobe ##1 !preload_strobe)
		else $error("preload strobe missing or too long");
	a_ctrl_direct: assert property (reg_wr && reg_addr == OFF_CONTROL_SECOND |=>
		char_size == $past(reg_wdata[2:0]) && hw_select_enable == $past(reg_wdata[13])
		&& select_low_detect_enable == $past(reg_wdata[9])
		&& slave_preload_enable == $past(reg_wdata[6]))
		else $error("control fields not taken from write");
	a_baud_write: assert property (reg_wr && reg_addr == OFF_BAUD_DIVIDER |=>
		baud_divider == $past(reg_wdata[7:0])) else $error("baud write lost");
	a_baud_hold: assert property (!(reg_wr && reg_addr == OFF_BAUD_DIVIDER) |=>
		$stable(baud_divider)) else $error("baud changed without write");
	a_select_drive: assert property (1'b1 |=>
		select_out_b == !$past(hw_select_enable && master_mode && xfer_active))
		else $error("hardware select wrong");
	a_wake_fall: assert property ($fell(select_pin) && select_low_detect_enable
		&& !master_mode |-> ##[1:2] wake_req) else $error("wake missing");
	a_wake_once: assert property (wake_req |=> !wake_req)
		else $error("wake longer than one cycle");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_tx_load: assert property (reg_wr && reg_addr == OFF_DATA && master_mode
		&& !tx_word_valid |=> tx_word_valid && tx_word == $past(reg_wdata[8:0]))
		else $error("transmit word not loaded");
endmodule : spic_ctrl_irq_sva

bind spic_ctrl_irq spic_ctrl_irq_sva spic_ctrl_irq_sva_i (.*);

`default_nettype wire

// File: tb_spi_ctrl_irq_regs.sv
// self-checking bench for the spi control and interrupt block
// assumes the loopback engine model on the far side
`default_nettype none

module tb_spi_ctrl_irq_regs;
	import spic_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, master_mode = 0;
	logic rx_enable = 1, select_pin = 1, addr_match_enable = 0, addr_match = 0, rx_overflow = 0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0, reg_rdata;
	logic [CHAR_W-1:0] rx_data, tx_word;
	logic [7:0] baud_divider;
	logic [2:0] char_size;
	logic tx_taken, shift_done, xfer_active, rx_valid, hw_select_enable, select_low_detect_enable;
	logic slave_preload_enable, tx_word_valid, preload_strobe, select_out_b, wake_req, irq;
	int bad_count = 0, n_checks = 0, cyc = 0;
	localparam logic [7:0] FL = OFF_IRQ_FLAG_STATUS;

	spic_ctrl_irq spic_ctrl_irq_i (.*);
	spic_engine_model spic_engine_model_i (.*);

	always #5 clock = ~clock;

	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	// cap well above the hundred and fifty or so cycles the run needs
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			bad_count++;
			wrap_up;
		end
	end

	task chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [DATA_W-1:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clock);
		reg_wr = 0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [DATA_W-1:0] e);
		@(negedge clock);
		reg_addr = a;
		reg_rd = 1;
		@(negedge clock);
		reg_rd = 0;
		chk(reg_rdata, e);
	endtask : rd

	// waits for the loopback delivery, then lets the flags settle
	task wait_rx(output logic lo);
		lo = 0;
		for (int i = 0; i < 40 && rx_valid !== 1'b1; i++)
		begin
			@(negedge clock);
			lo |= !select_out_b;
		end
		repeat (2) @(negedge clock);
	endtask : wait_rx

	task t_regs;
		rd(OFF_BAUD_DIVIDER, 32'h0);
		rd(FL, 32'h01);
		rd(8'h08, 32'h0);
		wr(OFF_IRQ_ENABLE_SET, 32'hff);
		rd(OFF_IRQ_ENABLE_CLEAR, 32'h8f);
		wr(OFF_IRQ_ENABLE_CLEAR, 32'h0a);
		rd(OFF_IRQ_ENABLE_SET, 32'h85);
		chk(irq, 32'h1);
		wr(OFF_IRQ_ENABLE_CLEAR, 32'hff);
		rd(OFF_IRQ_ENABLE_SET, 32'h0);
		chk(irq, 32'h0);
		for (int c = 0; c < 2; c++)
		begin
			wr(OFF_CONTROL_SECOND, 32'h2000 | c);
			chk(char_size, c);
		end
		wr(OFF_BAUD_DIVIDER, 32'h1a5);
		rd(OFF_BAUD_DIVIDER, 32'ha5);
	endtask : t_regs

	task t_master;
		logic lo;
		master_mode = 1'b1;
		wr(OFF_IRQ_ENABLE_SET, 32'h04);
		wr(OFF_DATA, 32'h1a5);
		wait_rx(lo);
		chk(lo, 32'h1);
		chk(irq, 32'h1);
		rd(FL, 32'h07);
		rd(OFF_DATA, 32'h1a5);
		chk(irq, 32'h0);
		wr(FL, 32'h07);
		rd(FL, 32'h01);
		wr(OFF_DATA, 32'h011);
		wait_rx(lo);
		wr(OFF_DATA, 32'h022);
		// new data clears tx complete and empty while the old word is unread
		rd(FL, 32'h04);
		wait_rx(lo);
		rd(FL, 32'h87);
		rd(OFF_STATUS, 32'h04);
		rd(OFF_DATA, 32'h0);
		wr(FL, 32'h80);
		wr(OFF_STATUS, 32'h04);
		rd(OFF_STATUS, 32'h0);
		rd(FL, 32'h03);
	endtask : t_master

	// engine overflow pulse, then receiver disable flushes buffer and status
	task t_flush;
		logic lo;
		wr(OFF_DATA, 32'h033);
		wait_rx(lo);
		rx_overflow = 1'b1;
		@(negedge clock);
		rx_overflow = 1'b0;
		rd(FL, 32'h87);
		rd(OFF_STATUS, 32'h04);
		rx_enable = 1'b0;
		@(negedge clock);
		rx_enable = 1'b1;
		rd(OFF_STATUS, 32'h0);
		rd(FL, 32'h83);
		wr(FL, 32'h82);
		rd(FL, 32'h01);
	endtask : t_flush

	task t_slave;
		logic w;
		master_mode = 1'b0;
		w = 1'b0;
		wr(OFF_CONTROL_SECOND, 32'h200);
		wr(FL, 32'h02);
		select_pin = 1'b0;
		repeat (4) @(negedge clock) w |= wake_req;
		chk(w, 32'h1);
		rd(FL, 32'h09);
		select_pin = 1'b1;
		repeat (3) @(negedge clock);
		rd(FL, 32'h0b);
		wr(FL, 32'h0a);
		rd(FL, 32'h01);
		wr(OFF_CONTROL_SECOND, 32'h40);
		wr(OFF_DATA, 32'h155);
		chk(preload_strobe, 32'h1);
		chk(tx_word_valid, 32'h0);
	endtask : t_slave

	// idle engine shows the inverse of its last word, 0x033, as the address
	task t_match;
		addr_match_enable = 1'b1;
		select_pin = 1'b0;
		repeat (2) @(negedge clock);
		select_pin = 1'b1;
		repeat (2) @(negedge clock);
		rd(FL, 32'h01);
		select_pin = 1'b0;
		@(negedge clock);
		addr_match = 1'b1;
		@(negedge clock);
		addr_match = 1'b0;
		select_pin = 1'b1;
		repeat (2) @(negedge clock);
		rd(FL, 32'h07);
		rd(OFF_DATA, 32'h1cc);
		addr_match_enable = 1'b0;
	endtask : t_match

	initial
	begin
		repeat (12) @(negedge clock);
		rst_b = 1'b1;
		t_regs;
		t_master;
		t_flush;
		t_slave;
		t_match;
		wrap_up;
	end
endmodule : tb_spi_ctrl_irq_regs

`default_nettype wire
